//--- dram_host_checker.sv
// Purpose: Port checker for the memory timing controller.
// Assumes: One clock domain; strobe polarity is not visible here.
// Notes:   Relations compare strobes so they hold for either polarity.
`timescale 1ns/100ps
`default_nettype none
module dram_host_checker (
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic        row_strobe_in,
	input wire logic        col_strobe_in,
	input wire logic        addr_half_select,
	input wire logic        mode_ctl_lo,
	input wire logic        mode_ctl_hi,
	input wire logic        latch_open,
	input wire logic        chip_select_n,
	input wire logic [19:0] addr_out
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	a_half_mode_ok: assert property (addr_half_select |-> mode_ctl_hi != mode_ctl_lo)
		else $error("half select high outside access or scrub");
	a_cs_idle_high: assert property (chip_select_n |-> row_strobe_in == col_strobe_in)
		else $error("strobe active while not selected");
	a_row_then_col: assert property ($rose(addr_half_select) |->
		row_strobe_in != col_strobe_in ##2 row_strobe_in == col_strobe_in)
		else $error("column strobe not after row strobe");
	a_mode_hold: assert property (!chip_select_n && $past(!chip_select_n) |->
		$stable({mode_ctl_hi, mode_ctl_lo})) else $error("mode changed inside a cycle");
	a_addr_hold: assert property (!chip_select_n && $past(!chip_select_n) |->
		$stable(addr_out)) else $error("address changed inside a cycle");
	a_latch_access: assert property ($rose(latch_open) |-> mode_ctl_hi && !mode_ctl_lo
		&& !chip_select_n ##2 !latch_open) else $error("latch opened outside access");
	a_cycle_min: assert property ($fell(chip_select_n) |-> !chip_select_n [*6])
		else $error("cycle shorter than three phases");
	a_cycle_max: assert property ($fell(chip_select_n) |-> ##[6:10] chip_select_n)
		else $error("cycle longer than five phases");
	a_refresh_no_col: assert property (!chip_select_n && mode_ctl_hi == mode_ctl_lo |->
		$stable(col_strobe_in)) else $error("column strobe moved in row-only cycle");
endmodule
`default_nettype wire

//--- dram_host_ctrl.sv
// Purpose: Memory timing controller that sequences the address multiplexer
//          and refresh counter device through its strobe and mode pins.
// Assumes: One 40 MHz clock, synchronous active-low reset, APB slave port.
// Notes:   Every device pin and every APB output comes from a flip-flop.
//
// Summary of operation
// - Scrub mode may write pattern at power-up
// - Latch_open may be held high permanently
// - More banks need per-device chip select
// - Scrubbing runs read-modify-write at counter addresses
// - Controller generates strobes, half select, modes
// - Controller arbitrates refresh against access cycles
// - Top address bits drive the bank picks
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module dram_host_ctrl
#(
	parameter int unsigned REFRESH_PERIOD = dram_host_pkg::REFRESH_CYCLES,
	parameter int unsigned PHASE_LEN      = dram_host_pkg::PHASE_CYCLES
)
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        row_strobe_in,
	output var  logic        col_strobe_in,
	output var  logic        addr_half_select,
	output var  logic        mode_ctl_lo,
	output var  logic        mode_ctl_hi,
	output var  logic        latch_open,
	output var  logic        chip_select_n,
	output var  logic        bank_pick_0,
	output var  logic        bank_pick_1,
	output var  logic [19:0] addr_out
);
	import dram_host_pkg::*;

	// ------------------------------------------------------------------
	// Registers and decode
	// ------------------------------------------------------------------
	state_t                   state_q;
	state_t                   state_d;
	logic [PHASE_CNT_W-1:0]   phase_q;
	logic [CTRL_W-1:0]        ctrl_q;
	logic [LATCH_W-1:0]       addr_q;
	logic                     acc_pend_q;
	logic                     clr_pend_q;
	logic                     ref_pend_q;
	logic [TIMER_W-1:0]       timer_q;
	logic [15:0]              ref_count_q;

	wire setup_phase = psel & ~penable;
	wire access_done = psel & penable & pready;
	wire wr_done     = access_done & pwrite;
	wire hit_ctrl    = (paddr == REG_CTRL);
	wire hit_addr    = (paddr == REG_ADDR);
	wire hit_cmd     = (paddr == REG_CMD);
	wire hit_status  = (paddr == REG_STATUS);
	wire addr_ok     = hit_ctrl | hit_addr | hit_cmd | hit_status;
	wire idle        = (state_q == ST_IDLE);

	wire [31:0] status_word = {ref_count_q, 12'h000, ref_pend_q, clr_pend_q,
		acc_pend_q, ~idle};
	wire [31:0] rd_data = hit_ctrl ? {27'h0000000, ctrl_q} :
		hit_addr ? {10'h000, addr_q} :
		hit_status ? status_word : 32'h00000000;

	// ------------------------------------------------------------------
	// Arbitration
	// ------------------------------------------------------------------
	// Clearing and refresh outrank a waiting access, so an access asked for
	// during a refresh starts right after it instead of stretching refresh.
	// The timer wraps at the period even while refresh is off, so the first
	// request after enabling comes within one period, not one full timer wrap.
	wire timer_wrap = (timer_q == TIMER_W'(REFRESH_PERIOD - 1));
	wire timer_tick = ctrl_q[CTRL_REFRESH_EN] & timer_wrap;
	wire start_clr  = idle & clr_pend_q;
	wire start_ref  = idle & ~clr_pend_q & ref_pend_q;
	wire start_acc  = idle & ~clr_pend_q & ~ref_pend_q & acc_pend_q;
	wire start_any  = start_clr | start_ref | start_acc;
	wire [1:0] refresh_mode = ctrl_q[CTRL_SCRUB] ? MODE_SCRUB : MODE_REFRESH;
	wire [1:0] start_mode = start_clr ? MODE_CLEAR :
		start_ref ? refresh_mode : MODE_ACCESS;
	wire [1:0] mode_now = {mode_ctl_hi, mode_ctl_lo};
	wire [1:0] mode_d   = start_any ? start_mode : mode_now;
	wire uses_column = (mode_now == MODE_SCRUB) | (mode_now == MODE_ACCESS);
	wire phase_done  = (phase_q == PHASE_CNT_W'(PHASE_LEN - 1));

	// ------------------------------------------------------------------
	// Cycle sequencer
	// ------------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (start_any)
					state_d = ST_SETUP;
			ST_SETUP:
				if (phase_done)
					state_d = ST_ROW;
			ST_ROW:
				if (phase_done)
					state_d = uses_column ? ST_MUX : ST_RECOVER;
			ST_MUX:
				if (phase_done)
					state_d = ST_COL;
			ST_COL:
				if (phase_done)
					state_d = ST_RECOVER;
			ST_RECOVER:
				if (phase_done)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	// Next pin levels, expressed as active-high before polarity is applied.
	wire ras_act  = (state_d == ST_ROW) | (state_d == ST_MUX) | (state_d == ST_COL);
	wire cas_act  = (state_d == ST_COL);
	wire half_d   = (state_d == ST_MUX) | (state_d == ST_COL);
	wire inactive = ~ctrl_q[CTRL_ACTIVE_HIGH];
	wire latch_d  = ctrl_q[CTRL_LATCH_HOLD] |
		((state_d == ST_SETUP) & (mode_d == MODE_ACCESS));
	wire done_ref = (state_q == ST_RECOVER) & phase_done & ~mode_ctl_hi;

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			state_q <= ST_IDLE;
			phase_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			phase_q <= (state_d != state_q) ? '0 : phase_q + 1'b1;
		end
	end

	// The inactive strobe edge at the end of each refresh, scrub or clear cycle is what steps or
	// clears the counters inside the device; no separate pulse is needed.
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			row_strobe_in    <= 1'b1;
			col_strobe_in    <= 1'b1;
			addr_half_select <= 1'b0;
			mode_ctl_hi      <= 1'b0;
			mode_ctl_lo      <= 1'b0;
			latch_open       <= 1'b0;
			chip_select_n    <= 1'b1;
		end
		else
		begin
			row_strobe_in    <= ras_act ^ inactive;
			col_strobe_in    <= cas_act ^ inactive;
			addr_half_select <= half_d;
			{mode_ctl_hi, mode_ctl_lo} <= mode_d;
			latch_open       <= latch_d;
			chip_select_n    <= ~(ctrl_q[CTRL_CS_EN] & (state_d != ST_IDLE));
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			addr_out    <= '0;
			bank_pick_0 <= 1'b0;
			bank_pick_1 <= 1'b0;
		end
		else if (start_acc)
		begin
			addr_out    <= addr_q[BANK_LSB-1:0];
			bank_pick_0 <= addr_q[BANK_LSB];
			bank_pick_1 <= addr_q[BANK_LSB+1];
		end
	end

	// ------------------------------------------------------------------
	// Refresh timer and pending requests
	// ------------------------------------------------------------------
	// Each pending flag lets a new request win over the start that clears it.
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			timer_q     <= '0;
			ref_pend_q  <= 1'b0;
			acc_pend_q  <= 1'b0;
			clr_pend_q  <= 1'b0;
			ref_count_q <= '0;
		end
		else
		begin
			timer_q     <= timer_wrap ? '0 : timer_q + 1'b1;
			ref_pend_q  <= timer_tick | (ref_pend_q & ~start_ref);
			acc_pend_q  <= (wr_done & hit_cmd & pwdata[CMD_ACCESS]) |
				(acc_pend_q & ~start_acc);
			clr_pend_q  <= (wr_done & hit_cmd & pwdata[CMD_CLEAR]) |
				(clr_pend_q & ~start_clr);
			if (done_ref)
				ref_count_q <= ref_count_q + 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			ctrl_q <= CTRL_RESET;
			addr_q <= '0;
		end
		else if (wr_done)
		begin
			if (hit_ctrl)
				ctrl_q <= pwdata[CTRL_W-1:0];
			if (hit_addr)
				addr_q <= pwdata[LATCH_W-1:0];
		end
	end

	// No wait state: the answer is prepared in the setup cycle.
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else if (setup_phase)
		begin
			pready  <= 1'b1;
			pslverr <= ~addr_ok;
			prdata  <= rd_data;
		end
		else if (access_done)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule

`default_nettype wire

//--- dram_host_pkg.sv
// Purpose: Shared constants for the memory timing controller that drives the
//          address multiplexer and refresh counter device.
// Assumes: 40 MHz core clock; APB register window with 32-bit data.
// Notes:   Timing counts are derived here from times in nanoseconds.
package dram_host_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_CMD    = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;

	localparam int CTRL_W             = 5;
	localparam int CTRL_REFRESH_EN    = 0;
	localparam int CTRL_SCRUB         = 1;
	localparam int CTRL_ACTIVE_HIGH   = 2;
	localparam int CTRL_LATCH_HOLD    = 3;
	localparam int CTRL_CS_EN         = 4;
	localparam logic [4:0] CTRL_RESET = 5'h11;

	localparam int CMD_ACCESS         = 0;
	localparam int CMD_CLEAR          = 1;

	localparam int STAT_BUSY          = 0;
	localparam int STAT_ACC_PEND      = 1;
	localparam int STAT_CLR_PEND      = 2;
	localparam int STAT_REF_PEND      = 3;
	localparam int STAT_COUNT_LSB     = 16;

	// ------------------------------------------------------------------
	// Device address layout
	// ------------------------------------------------------------------
	localparam int ROW_W   = 10;
	localparam int COL_W   = 10;
	localparam int BANK_W  = 2;
	localparam int LATCH_W = ROW_W + COL_W + BANK_W;
	localparam int BANK_LSB = ROW_W + COL_W;

	// Mode pin codes, written as {mode_ctl_hi, mode_ctl_lo}.
	localparam logic [1:0] MODE_REFRESH = 2'b00;
	localparam logic [1:0] MODE_SCRUB   = 2'b01;
	localparam logic [1:0] MODE_ACCESS  = 2'b10;
	localparam logic [1:0] MODE_CLEAR   = 2'b11;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ        = 40;
	localparam int T_PHASE_NS     = 50;
	localparam int PHASE_CYCLES   = (T_PHASE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_REFRESH_NS   = 15000;
	localparam int REFRESH_CYCLES = (T_REFRESH_NS * CLK_MHZ) / 1000;
	localparam int PHASE_CNT_W    = 8;
	localparam int TIMER_W        = 12;

	typedef enum logic [5:0] {
		ST_IDLE    = 6'b000001,
		ST_SETUP   = 6'b000010,
		ST_ROW     = 6'b000100,
		ST_MUX     = 6'b001000,
		ST_COL     = 6'b010000,
		ST_RECOVER = 6'b100000
	} state_t;

endpackage

//--- dram_mux_model.sv
// Purpose: Behavioural model of the address multiplexer and refresh counter.
// Assumes: Strobe outputs are active low toward the memory banks.
// Notes:   Counters only move while selected, so polarity changes are safe.
`timescale 1ns/100ps
`default_nettype none
module dram_mux_model #(parameter int LINES = 128) (
	input wire logic        row_strobe_in,
	input wire logic        col_strobe_in,
	input wire logic        addr_half_select,
	input wire logic        mode_ctl_lo,
	input wire logic        mode_ctl_hi,
	input wire logic        latch_open,
	input wire logic        chip_select_n,
	input wire logic        bank_pick_0,
	input wire logic        bank_pick_1,
	input wire logic [19:0] addr_out,
	input wire logic        active_high,
	output logic     [9:0]  mem_addr,
	output logic     [3:0]  row_sel_n,
	output logic     [3:0]  col_sel_n
);
	import dram_host_pkg::*;
	logic [21:0] lat;
	logic [9:0]  row_q = 10'h0;
	logic [9:0]  col_q = 10'h0;
	logic [1:0]  bank_q = 2'h0;
	wire         act_r = row_strobe_in == active_high;
	wire         act_c = col_strobe_in == active_high;
	wire  [1:0]  mode = {mode_ctl_hi, mode_ctl_lo};
	always_latch if (latch_open) lat <= {bank_pick_1, bank_pick_0, addr_out};
	assign mem_addr = mode == MODE_ACCESS ? (addr_half_select ? lat[19:10] : lat[9:0])
		: (mode == MODE_SCRUB && addr_half_select ? col_q : row_q);
	assign row_sel_n = chip_select_n ? 4'hf : mode == MODE_ACCESS
		? ~(4'(act_r) << lat[21:20]) : {4{~act_r}};
	assign col_sel_n = (chip_select_n || mode_ctl_hi == mode_ctl_lo) ? 4'hf
		: ~(4'(act_c) << (mode_ctl_hi ? lat[21:20] : bank_q));
	always @(row_strobe_in)
		if (!chip_select_n && !act_r)
			if (mode == MODE_CLEAR) {bank_q, col_q, row_q} <= 22'h0;
			else if (!mode_ctl_hi)
			begin
				row_q <= 10'((row_q + 1) % LINES);
				if (row_q == LINES - 1) {bank_q, col_q} <= {bank_q, col_q} + 12'h1;
			end
endmodule
`default_nettype wire

//--- test_dram_host_ctrl.sv
// Purpose: Self-checking bench for the memory timing controller.
// Assumes: Device model on the strobe side; APB master in this file.
// Notes:   The refresh period is shortened so refresh runs stay brief.
`timescale 1ns/100ps
`default_nettype none
module test_dram_host_ctrl;
	import dram_host_pkg::*;
	logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, note = 0, active_high = 0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd, v;
	logic pready, pslverr, row_strobe_in, col_strobe_in, addr_half_select, mode_ctl_lo;
	logic mode_ctl_hi, latch_open, chip_select_n, bank_pick_0, bank_pick_1;
	logic [19:0] addr_out;
	logic [9:0] mem_addr;
	logic [3:0] row_sel_n, col_sel_n, pr = 4'hf, pc = 4'hf;
	logic [32:0] q[$];
	int failures = 0, checks_done = 0, seed = 60190;
	always #12.5 core_clk = ~core_clk;
	dram_host_ctrl #(.REFRESH_PERIOD(40), .PHASE_LEN(2)) i_dram_host_ctrl (.core_clk, .reset_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .row_strobe_in,
		.col_strobe_in, .addr_half_select, .mode_ctl_lo, .mode_ctl_hi, .latch_open,
		.chip_select_n, .bank_pick_0, .bank_pick_1, .addr_out);
	dram_mux_model i_dram_mux_model (.row_strobe_in, .col_strobe_in, .addr_half_select,
		.mode_ctl_lo, .mode_ctl_hi, .latch_open, .chip_select_n, .bank_pick_0, .bank_pick_1,
		.addr_out, .active_high, .mem_addr, .row_sel_n, .col_sel_n);
	function logic [32:0] ev(input logic [3:0] r, c, input logic [9:0] m);
		return {15'h0, r, c, m};
	endfunction
	task chk(input logic [32:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			failures++;
		end
	endtask
	task summarize;
		if (q.size() != 0) failures++;
		$display("checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Entered just after a rising edge; one idle edge follows each transfer.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e,
		input logic [32:0] x);
		int t;
		if (e) q.push_back(x);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; note <= e;
		@(posedge core_clk) penable <= 1;
		t = 0;
		do @(posedge core_clk); while (pready !== 1'b1 && ++t < 50);
		if (pready !== 1'b1) failures++;
		rd = prdata;
		psel <= 0; penable <= 0; note <= 0;
		@(posedge core_clk);
	endtask
	// Stops new refreshes once the completed count reaches k.
	task refresh(input logic [31:0] c, input int k);
		int t;
		apb(1, REG_CTRL, c, 0, 0);
		t = 0;
		do apb(0, REG_STATUS, 0, 0, 0); while (rd[31:16] < k && ++t < 500);
		if (rd[31:16] < k) failures++;
		apb(1, REG_CTRL, c & 32'h1e, 0, 0);
	endtask
	always @(posedge core_clk)
		if (psel && penable && pready === 1'b1 && note) chk({pslverr, prdata}, q.pop_front());
	always @(negedge core_clk)
	begin
		if (|(pr & ~row_sel_n) || |(pc & ~col_sel_n))
			chk(ev(row_sel_n, col_sel_n, mem_addr), q.pop_front());
		pr = row_sel_n;
		pc = col_sel_n;
	end
	initial
	begin
		repeat (16) @(posedge core_clk);
		reset_n <= 1;
		@(posedge core_clk);
		apb(0, REG_CTRL, 0, 1, 33'h11);
		apb(0, 8'h10, 0, 1, 33'h100000000);
		apb(1, REG_CTRL, 32'h10, 0, 0);
		$display("test registers done");
		for (int b = 0; b < 4; b++)
		begin
			v = ($random(seed) & 32'hfffff) | (b << 20);
			q.push_back(ev(~(4'h1 << b), 4'hf, v[9:0]));
			q.push_back(ev(~(4'h1 << b), ~(4'h1 << b), v[19:10]));
			apb(1, REG_ADDR, v, 0, 0);
			apb(1, REG_CMD, 32'h1, 0, 0);
			repeat (12) @(posedge core_clk);
		end
		$display("test access done");
		for (int n = 0; n < 3; n++)
		begin
			q.push_back(ev(4'h0, 4'hf, 10'(n)));
			q.push_back(ev(4'h0, 4'he, 10'h0));
		end
		refresh(32'h13, 3);
		$display("test scrub done");
		q.push_back(ev(4'h0, 4'hf, 10'h3));
		apb(1, REG_CMD, 32'h2, 0, 0);
		repeat (10) @(posedge core_clk);
		active_high <= 1;
		q.push_back(ev(4'h0, 4'hf, 10'h0));
		refresh(32'h15, 4);
		apb(0, REG_STATUS, 0, 1, 33'h40000);
		$display("test clear and polarity done");
		summarize();
	end
	initial
	begin
		#500000;
		failures++;
		summarize();
	end
endmodule
bind dram_host_ctrl dram_host_checker i_dram_host_checker (.core_clk, .reset_n, .row_strobe_in,
	.col_strobe_in, .addr_half_select, .mode_ctl_lo, .mode_ctl_hi, .latch_open, .chip_select_n,
	.addr_out);
`default_nettype wire
